// file: testbench/sfic_shifter_model.sv
// behavioural serial shifter standing on the fifo side of sfic_top
// assumes ref_clk is shared with the design; the bench calls pop and push
`timescale 1ns/100ps

module sfic_shifter_model (
  input wire logic ref_clk, // system clock
  input wire logic sh_tx_valid, // tx head valid
  output logic sh_tx_ready, // pop request
  input wire logic [31:0] sh_tx_data, // tx head word
  output logic sh_rx_valid, // rx word offered
  input wire logic sh_rx_ready, // rx fifo room, ignored on purpose
  output logic [31:0] sh_rx_data, // rx word
  output logic [31:0] last_tx // word taken by the last pop
);
  initial begin
    sh_tx_ready = 1'b0;
    sh_rx_valid = 1'b0;
    sh_rx_data = 32'h5A5A5A5A;
    last_tx = 32'h00000000;
  end

  // ---------------------------------------------------------------
  // transfers
  // ---------------------------------------------------------------
  // pops even when empty, so underrun is reachable
  task automatic pop();
    @(negedge ref_clk);
    sh_tx_ready = 1'b1;
    last_tx = sh_tx_data;
    @(negedge ref_clk);
    sh_tx_ready = 1'b0;
  endtask

  // offers even when full, so overrun is reachable
  task automatic push(input logic [31:0] w);
    @(negedge ref_clk);
    sh_rx_valid = 1'b1;
    sh_rx_data = w;
    @(negedge ref_clk);
    sh_rx_valid = 1'b0;
    sh_rx_data = ~w; // stale data never looks valid
  endtask
endmodule

// file: testbench/sfic_top_tb.sv
// self-checking bench for sfic_top: apb-style register tasks plus shifter model
// assumes sfic_pkg, the design files and the shifter model are compiled first
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module sfic_top_tb;
  import sfic_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = STRB_WORD;
  logic [DATA_W-1:0] prdata, sh_tx_data, sh_rx_data, last_tx, rd;
  logic pready, pslverr, irq, sclk, sh_tx_valid, sh_tx_ready, sh_rx_valid, sh_rx_ready, err;
  logic master_mode = 1'b1;
  logic [LVL_W-1:0] rx_half_level = 5'h08;
  logic [LVL_W-1:0] tx_half_level = 5'h08;
  logic [7:0] n;
  int n_errors = 0;
  int checks = 0;

  sfic_top sfic_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .master_mode(master_mode),
    .rx_half_level(rx_half_level), .tx_half_level(tx_half_level), .sclk(sclk),
    .sh_tx_valid(sh_tx_valid), .sh_tx_ready(sh_tx_ready), .sh_tx_data(sh_tx_data),
    .sh_rx_valid(sh_rx_valid), .sh_rx_ready(sh_rx_ready), .sh_rx_data(sh_rx_data));

  sfic_shifter_model sfic_shifter_model_i (.ref_clk(ref_clk), .sh_tx_valid(sh_tx_valid),
    .sh_tx_ready(sh_tx_ready), .sh_tx_data(sh_tx_data), .sh_rx_valid(sh_rx_valid),
    .sh_rx_ready(sh_rx_ready), .sh_rx_data(sh_rx_data), .last_tx(last_tx));

  // 50 MHz clock
  initial begin
    forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one access: setup, access, hold until pready seen, then release
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int k;
    @(negedge ref_clk);
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    pstrb = s;
    @(negedge ref_clk);
    penable = 1'b1;
    for (k = 0; k < 8 && pready !== 1'b1; k++) @(negedge ref_clk);
    if (k == 8) begin
      n_errors++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    @(negedge ref_clk);
    psel = 1'b0;
    penable = 1'b0;
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    apb(1'b1, a, d, STRB_WORD);
  endtask

  task automatic rchk(input logic [13:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h00000000, STRB_WORD);
    `CHK(nm, e, rd)
  endtask

  task automatic sclk_count(input logic [7:0] e);
    n = 8'h00;
    repeat (20) begin
      @(negedge ref_clk);
      if (sclk === 1'b1) n++;
    end
    `CHK("sclk highs", e, n)
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    rchk(OFS_MASK, 32'h000007FF, "mask reset");
    rchk(OFS_DIV, 32'h00000002, "div reset");
    rchk(OFS_RAW, 32'h00000000, "raw reset");
    rchk(OFS_CLEAR, 32'h00000000, "clear reads 0");
    wr(OFS_RAW, 32'h000007FF);
    rchk(OFS_RAW, 32'h00000000, "raw read only");
    rchk(14'h0010, 32'h00000000, "unmapped");
    `CHK("unmapped err", 1'b1, err)
    rchk(14'h1000, 32'h00000000, "tx window read");
    `CHK("tx read err", 1'b1, err)
    // divisor 0 and 1 are never programmed here
    // legal divisors only
    sclk_count(8'h0A);
    wr(OFS_DIV, 32'h00000005);
    rchk(OFS_DIV, 32'h00000005, "div rw");
    sclk_count(8'h0C);
    master_mode = 1'b0;
    sclk_count(8'h00);
    master_mode = 1'b1;
    // fill tx to full, then one more write
    for (int i = 0; i < 17; i++) wr(14'h1000, 32'h10000000 + i);
    rchk(OFS_RAW, 32'h00000080, "tx overflow");
    `CHK("tx valid full", 1'b1, sh_tx_valid)
    sfic_shifter_model_i.pop();
    `CHK("first tx word", 32'h10000000, last_tx)
    rchk(OFS_RAW, 32'h00000084, "tx not full");
    repeat (15) sfic_shifter_model_i.pop();
    `CHK("last tx word", 32'h1000000F, last_tx)
    rchk(OFS_RAW, 32'h00000087, "tx drained");
    `CHK("tx valid empty", 1'b0, sh_tx_valid)
    sfic_shifter_model_i.pop();
    rchk(OFS_RAW, 32'h00000187, "tx underrun");
    // irq follows unmasked raw bits only
    `CHK("irq masked", 1'b0, irq)
    wr(OFS_MASK, 32'h000007FE);
    `CHK("irq unmasked", 1'b1, irq)
    wr(OFS_CLEAR, 32'h00000000);
    rchk(OFS_RAW, 32'h00000187, "clear zero");
    wr(OFS_CLEAR, 32'h00000001);
    rchk(OFS_RAW, 32'h00000186, "clear bit0");
    `CHK("irq cleared", 1'b0, irq)
    wr(OFS_MASK, 32'h000007FF);
    wr(OFS_CLEAR, 32'h000007FF);
    // byte packing then a misaligned word write
    for (int i = 1; i < 5; i++) apb(1'b1, 14'h1000, 32'h00000011 * i, 4'h1);
    sfic_shifter_model_i.pop();
    `CHK("packed word", 32'h44332211, last_tx)
    apb(1'b1, 14'h1000, 32'h00000055, 4'h1);
    wr(14'h1000, 32'hDEADBEEF);
    rchk(OFS_RAW, 32'h00000041, "misaligned");
    wr(OFS_CLEAR, 32'h000007FF);
    // rx: idle byte, token, then fill and overrun
    sfic_shifter_model_i.push(32'h000000FF);
    sfic_shifter_model_i.push(32'h000000FE);
    for (int i = 2; i < 16; i++) sfic_shifter_model_i.push(32'h000000A0 + i);
    rchk(OFS_RAW, 32'h00000438, "rx full");
    `CHK("rx ready full", 1'b0, sh_rx_ready)
    sfic_shifter_model_i.push(32'h000000BB);
    rchk(OFS_RAW, 32'h00000638, "rx overrun");
    rchk(14'h2000, 32'h000000FF, "rx word 0");
    `CHK("rx ready again", 1'b1, sh_rx_ready)
    rchk(14'h2000, 32'h000000FE, "rx word 1");
    for (int i = 2; i < 16; i++) rchk(14'h2000, 32'h000000A0 + i, "rx word");
    rchk(14'h2000, 32'h00000000, "rx empty read");
    rchk(OFS_RAW, 32'h00000678, "rx underflow");
    report_and_stop();
  end
endmodule

// file: verilog/sfic_pkg.sv
// constants and state layout for the spi fifo interrupt and clock divider block
// assumes one 50 MHz ref_clk domain and a 14-bit internal apb address
package sfic_pkg;
  // ---------------------------------------------------------------
  // bus and data shape
  // ---------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
  localparam int CLK_PERIOD_NS = 20;
  // ---------------------------------------------------------------
  // register offsets and windows
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_RAW = 14'h0000;
  localparam logic [ADDR_W-1:0] OFS_MASK = 14'h0004;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 14'h0008;
  localparam logic [ADDR_W-1:0] OFS_DIV = 14'h000C;
  localparam logic [1:0] WIN_REGS = 2'h0;
  localparam logic [1:0] WIN_TX = 2'h1;
  localparam logic [1:0] WIN_RX = 2'h2;
  // ---------------------------------------------------------------
  // interrupt source bit positions
  // ---------------------------------------------------------------
  localparam int NSRC = 11;
  localparam int SRC_TX_EMPTY = 0;
  localparam int SRC_TX_LEVEL = 1;
  localparam int SRC_TX_SPACE = 2;
  localparam int SRC_RX_NONEMPTY = 3;
  localparam int SRC_RX_LEVEL = 4;
  localparam int SRC_RX_FULL = 5;
  localparam int SRC_BUS_RX = 6;
  localparam int SRC_BUS_TX = 7;
  localparam int SRC_SER_TX = 8;
  localparam int SRC_SER_RX = 9;
  localparam int SRC_TOKEN = 10;
  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [NSRC-1:0] MASK_RST = 11'h7FF;
  localparam logic [DATA_W-1:0] DIV_RST = 32'h00000002;
  localparam logic [DATA_W-1:0] DIV_MIN = 32'h00000002;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [7:0] TOKEN_BYTE = 8'hFE;
  localparam logic [3:0] STRB_WORD = 4'hF;
endpackage

// file: verilog/sfic_top.sv
// spi fifo interrupt flags, mask, clear, clock divider and the two data fifos
// assumes the apb master, the serial shifter and the mode/threshold inputs
// all run on ref_clk; the shifter pulses sh_tx_ready only when it wants a word
//
// How it works
// - bus-side rx error: read of empty rx fifo or misaligned access sets bit 6
// - word write while byte pointer is not at byte 0 is misaligned
// - rx fifo reaching full sets bit 5
// - rx level rising above the half threshold sets bit 4
// - rx fifo going from empty to non-empty sets bit 3
// - tx fifo going from full to not full sets bit 2
// - tx level falling below the half threshold sets bit 1
// - tx fifo becoming empty sets bit 0
// - eleven mask bits, 1 masks, reset all masked to 0x7FF
// - writing 1 to a clear bit clears that raw source bit
// - serial clock is ref_clk divided by the 32-bit divisor, reset 2; divisor values 0 and 1 divide by 2
// - divisor only acts in master mode; slave mode ignores it
// - raw unmasked source flags read back at offset 0x00
// - received byte FF followed by FE sets bit 10
// - bus-side tx error: write to full tx fifo sets bit 7
// - serial-side rx overrun sets bit 9, tx underrun sets bit 8
`timescale 1ns/100ps

// ---------------------------------------------------------------
// generic fifo, flip-flop storage
// ---------------------------------------------------------------
module sfic_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // head word present
  input wire logic out_ready, // consume head
  output logic [WIDTH-1:0] out_data, // head word
  output logic [$clog2(DEPTH+1)-1:0] level // words held
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic in_ready;
    logic out_valid;
    logic [WIDTH-1:0] head;
  } sfic_fifo_state_type;
  sfic_fifo_state_type st;
  sfic_fifo_state_type next_st;
  logic push;
  logic pop;

  // full, empty and the head word are registered so every output comes from a flop
  always_comb begin
    next_st = st;
    push = in_valid && st.in_ready;
    pop = out_ready && st.out_valid;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = st.wp + PW'(1);
    end
    if (pop) begin
      next_st.rp = st.rp + PW'(1);
    end
    next_st.cnt = st.cnt + CW'(push) - CW'(pop);
    next_st.in_ready = next_st.cnt != CW'(DEPTH);
    next_st.out_valid = next_st.cnt != '0;
    next_st.head = next_st.mem[next_st.rp]; // word that will sit at the head
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.in_ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready = st.in_ready;
  assign out_valid = st.out_valid;
  assign out_data = st.head;
  assign level = st.cnt;
endmodule

// ---------------------------------------------------------------
// top: apb registers, flags, divider
// ---------------------------------------------------------------
module sfic_top (
  input wire logic ref_clk, // 50 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [sfic_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [sfic_pkg::DATA_W-1:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [sfic_pkg::DATA_W-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // unmapped address, tx window read or rx window write
  output logic irq, // interrupt, active high
  input wire logic master_mode, // 1 master, 0 slave
  input wire logic [sfic_pkg::LVL_W-1:0] rx_half_level, // rx threshold
  input wire logic [sfic_pkg::LVL_W-1:0] tx_half_level, // tx threshold
  output logic sclk, // master serial clock
  output logic sh_tx_valid, // tx word for shifter
  input wire logic sh_tx_ready, // shifter takes tx word
  output logic [sfic_pkg::DATA_W-1:0] sh_tx_data, // tx word
  input wire logic sh_rx_valid, // shifter offers rx word
  output logic sh_rx_ready, // rx fifo has room
  input wire logic [sfic_pkg::DATA_W-1:0] sh_rx_data // rx word
);
  import sfic_pkg::*;

  typedef struct packed {
    logic [NSRC-1:0] raw;
    logic [NSRC-1:0] mask;
    logic [DATA_W-1:0] div;
    logic [DATA_W-1:0] cnt;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] tx_word;
    logic [1:0] bptr;
    logic [LVL_W-1:0] prev_tx;
    logic [LVL_W-1:0] prev_rx;
    logic [7:0] last_byte;
    logic pready;
    logic pslverr;
    logic irq;
    logic sclk;
    logic tx_push;
    logic rx_pop;
  } sfic_state_type;

  sfic_state_type st;
  sfic_state_type next_st;
  logic [NSRC-1:0] set_vec;
  logic [NSRC-1:0] clr_vec;
  logic [DATA_W-1:0] div_eff;
  logic acc_cyc;
  logic tx_in_ready;
  logic rx_in_ready;
  logic rx_out_valid;
  logic [DATA_W-1:0] rx_out_data;
  logic [LVL_W-1:0] tx_lvl;
  logic [LVL_W-1:0] rx_lvl;

  // which window an address falls in
  function automatic logic [1:0] win_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:ADDR_W-2];
  endfunction

  // ---------------------------------------------------------------
  // data fifos
  // ---------------------------------------------------------------
  sfic_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(st.tx_push),
    .in_ready(tx_in_ready),
    .in_data(st.tx_word),
    .out_valid(sh_tx_valid),
    .out_ready(sh_tx_ready),
    .out_data(sh_tx_data),
    .level(tx_lvl)
  );

  sfic_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(sh_rx_valid),
    .in_ready(rx_in_ready),
    .in_data(sh_rx_data),
    .out_valid(rx_out_valid),
    .out_ready(st.rx_pop),
    .out_data(rx_out_data),
    .level(rx_lvl)
  );

  assign sh_rx_ready = rx_in_ready;
  assign acc_cyc = psel && penable && !st.pready;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // register access is taken in the first access cycle, pready follows
  always_comb begin
    next_st = st;
    set_vec = '0;
    clr_vec = '0;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.tx_push = 1'b0;
    next_st.rx_pop = 1'b0;
    div_eff = (st.div < DIV_MIN) ? DIV_MIN : st.div;
    if (acc_cyc) begin
      next_st.pready = 1'b1;
      next_st.prdata = '0;
      case (win_of(paddr))
        WIN_REGS: begin
          if (pwrite) begin
            case (paddr)
              OFS_MASK: next_st.mask = pwdata[NSRC-1:0];
              OFS_CLEAR: clr_vec = pwdata[NSRC-1:0];
              OFS_DIV: next_st.div = pwdata;
              OFS_RAW: next_st.pslverr = 1'b0;
              default: next_st.pslverr = 1'b1;
            endcase
          end else begin
            case (paddr)
              OFS_RAW: next_st.prdata = {{(DATA_W-NSRC){1'b0}}, st.raw};
              OFS_MASK: next_st.prdata = {{(DATA_W-NSRC){1'b0}}, st.mask};
              OFS_CLEAR: next_st.prdata = '0;
              OFS_DIV: next_st.prdata = st.div;
              default: next_st.pslverr = 1'b1;
            endcase
          end
        end
        WIN_TX: begin
          if (!pwrite) begin
            next_st.pslverr = 1'b1;
          end else if (pstrb == STRB_WORD) begin
            if (st.bptr != 2'h0) begin
              set_vec[SRC_BUS_RX] = 1'b1;
              next_st.bptr = 2'h0;
            end else if (!tx_in_ready) begin
              set_vec[SRC_BUS_TX] = 1'b1;
            end else begin
              next_st.tx_push = 1'b1;
              next_st.tx_word = pwdata;
            end
          end else begin
            // byte writes pack low byte first into one word
            next_st.acc[{st.bptr, 3'b000} +: 8] = pwdata[7:0];
            next_st.bptr = st.bptr + 2'h1;
            if (st.bptr == 2'h3) begin
              if (tx_in_ready) begin
                next_st.tx_push = 1'b1;
                next_st.tx_word = {pwdata[7:0], st.acc[23:0]};
              end else begin
                set_vec[SRC_BUS_TX] = 1'b1;
              end
            end
          end
        end
        WIN_RX: begin
          if (pwrite) begin
            next_st.pslverr = 1'b1;
          end else if (!rx_out_valid) begin
            set_vec[SRC_BUS_RX] = 1'b1;
          end else begin
            next_st.prdata = rx_out_data;
            next_st.rx_pop = 1'b1;
          end
        end
        default: next_st.pslverr = 1'b1;
      endcase
    end
    set_vec[SRC_SER_RX] = sh_rx_valid && !rx_in_ready;
    set_vec[SRC_SER_TX] = sh_tx_ready && !sh_tx_valid;
    if (sh_rx_valid && rx_in_ready) begin
      next_st.last_byte = sh_rx_data[7:0];
      if (st.last_byte == IDLE_BYTE && sh_rx_data[7:0] == TOKEN_BYTE) begin
        set_vec[SRC_TOKEN] = 1'b1;
      end
    end
    // level events are edges, judged against last cycle's fill
    // rx reaches full
    set_vec[SRC_RX_FULL] = rx_lvl == LVL_W'(FIFO_DEPTH) && st.prev_rx != LVL_W'(FIFO_DEPTH);
    set_vec[SRC_RX_LEVEL] = rx_lvl > rx_half_level && !(st.prev_rx > rx_half_level);
    set_vec[SRC_RX_NONEMPTY] = rx_lvl != '0 && st.prev_rx == '0;
    set_vec[SRC_TX_SPACE] = tx_lvl != LVL_W'(FIFO_DEPTH) && st.prev_tx == LVL_W'(FIFO_DEPTH);
    set_vec[SRC_TX_LEVEL] = tx_lvl < tx_half_level && !(st.prev_tx < tx_half_level);
    set_vec[SRC_TX_EMPTY] = tx_lvl == '0 && st.prev_tx != '0;
    next_st.prev_rx = rx_lvl;
    next_st.prev_tx = tx_lvl;
    // set wins over a clear in the same cycle
    next_st.raw = (st.raw & ~clr_vec) | set_vec;
    next_st.irq = |(next_st.raw & ~next_st.mask);
    // divide by div_eff, high for the upper half of the count
    if (master_mode) begin
      next_st.cnt = (st.cnt >= div_eff - 32'h1) ? '0 : st.cnt + 32'h1;
      next_st.sclk = next_st.cnt >= (div_eff >> 1);
    end else begin
      next_st.cnt = '0;
      next_st.sclk = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.mask <= MASK_RST;
      st.div <= DIV_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign sclk = st.sclk;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_acc;
    psel && penable && !st.pready;
  endsequence
  sequence s_clear_wr;
    s_acc ##0 (pwrite && paddr == OFS_CLEAR);
  endsequence

  chk_set_wins: assert property (|set_vec |=> ((st.raw & $past(set_vec)) == $past(set_vec)))
    else $error("set event lost");
  chk_clear_bit: assert property (s_clear_wr ##0 (pwdata[0] && !set_vec[0]) |=> !st.raw[0])
    else $error("clear did not clear bit 0");
  chk_irq_gate: assert property (irq == |(st.raw & ~st.mask))
    else $error("irq does not follow unmasked raw");
  chk_rx_full: assert property (rx_lvl == 5'h10 && $past(rx_lvl) == 5'h0F |=> st.raw[5])
    else $error("rx full flag missing");
  chk_rx_nonempty: assert property ($past(rx_lvl) == '0 && rx_lvl != '0 |=> st.raw[3])
    else $error("rx nonempty flag missing");
  chk_tx_empty: assert property ($past(tx_lvl) != '0 && tx_lvl == '0 |=> st.raw[0])
    else $error("tx empty flag missing");
  chk_tx_space: assert property ($past(tx_lvl) == 5'h10 && tx_lvl == 5'h0F |=> st.raw[2])
    else $error("tx space flag missing");
  chk_word_misalign: assert property (s_acc ##0 (pwrite && win_of(paddr) == WIN_TX
    && pstrb == 4'hF && st.bptr != 2'h0) |=> st.raw[6] && !st.tx_push)
    else $error("misaligned word not flagged");
  chk_slave_idle: assert property (!master_mode [*2] |-> !sclk)
    else $error("sclk runs in slave mode");
  chk_div_two: assert property ((master_mode && st.div == 32'h2) [*3] |-> sclk != $past(sclk))
    else $error("divide by two not toggling");
  chk_ser_overrun: assert property (sh_rx_valid && !sh_rx_ready |=> st.raw[9])
    else $error("serial overrun not flagged");
  chk_token: assert property (sh_rx_valid && sh_rx_ready && sh_rx_data[7:0] == 8'hFE
    && st.last_byte == 8'hFF |=> st.raw[10])
    else $error("start token not flagged");
endmodule
